// ### ssm_acc_if.sv
// Interface between the slot controller and one signed accumulator
interface ssm_acc_if #(
  parameter int DW = 14,
  parameter int AW = 27
);
  logic start;
  logic valid;
  logic subtract;
  logic [DW-1:0] data;
  logic signed [AW-1:0] sum;
  logic [1:0] pulse_idx;

  modport ctrl (output start, output valid, output subtract, output data, input sum, input pulse_idx);
  modport acc (input start, input valid, input subtract, input data, output sum, output pulse_idx);
endinterface

// ### ssm_pkg.sv
// Constants, types and decode functions for the slot sample math block
package ssm_pkg;

  // ==========================================
  // Register addresses
  localparam logic [7:0] ADDR_ORDER_A = 8'h17;
  localparam logic [7:0] ADDR_ORDER_B = 8'h1D;
  localparam logic [7:0] ADDR_INTEG_A = 8'h42;
  localparam logic [7:0] ADDR_FILT_A = 8'h43;
  localparam logic [7:0] ADDR_INTEG_B = 8'h44;
  localparam logic [7:0] ADDR_FILT_B = 8'h45;
  localparam logic [7:0] ADDR_MATH = 8'h58;

  // ==========================================
  // Values after reset
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [3:0] ORDER_RESET = 4'h0;

  // ==========================================
  // Field positions
  localparam int MATH12_A_LSB = 1;
  localparam int MATH12_B_LSB = 5;
  localparam int MATH34_A_LSB = 8;
  localparam int MATH34_B_LSB = 10;
  localparam int BUF_EN_BIT = 7;
  localparam int BUF_GAIN_BIT = 9;

  // ==========================================
  // Filter configuration codes
  localparam logic [15:0] FILT_DIRECT = 16'hB065;
  localparam logic [15:0] FILT_BUFFERED = 16'hAE65;

  // ==========================================
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int CHAN_SPACING_NS = 1000;
  localparam int CHAN_SPACING_CYC = CHAN_SPACING_NS / CLK_PERIOD_NS;
  localparam logic [1:0] LAST_CHAN = 2'h3;

  typedef enum logic {SEQ_IDLE, SEQ_RUN} ssm_seq_t;

  // Band-pass stage skipped for either bypass code
  function automatic logic ssm_band_pass_bypass(input logic [15:0] filt);
    return (filt == FILT_DIRECT) || (filt == FILT_BUFFERED);
  endfunction

  // Integrator skipped only in the direct code
  function automatic logic ssm_int_bypass(input logic [15:0] filt);
    return filt == FILT_DIRECT;
  endfunction

  // Subtract flag for a pulse position; high field bit is the earlier pulse
  function automatic logic ssm_sub_sel(input logic [1:0] pair12, input logic [1:0] pair34,
                                       input logic [1:0] idx);
    logic r;
    r = 1'b0;
    case (idx)
      2'h0: r = pair12[1];
      2'h1: r = pair12[0];
      2'h2: r = pair34[1];
      default: r = pair34[0];
    endcase
    return r;
  endfunction

endpackage

// ### ssm_sign_acc.sv
// Signed accumulator with four-pulse position counter for one time slot
module ssm_sign_acc #(
  parameter int DW = 14,
  parameter int AW = 27
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Controller side
  ssm_acc_if.acc bus
);

  typedef struct packed {
    logic [1:0] idx;
    logic signed [AW-1:0] sum;
  } ssm_acc_st_t;

  ssm_acc_st_t q;
  ssm_acc_st_t d;
  logic signed [AW-1:0] ext;
  logic signed [AW-1:0] base;
  logic [1:0] bidx;

  assign ext = signed'({{(AW-DW){1'b0}}, bus.data});
  assign bus.sum = q.sum;
  assign bus.pulse_idx = q.idx;

  // ==========================================
  // Next state
  always_comb begin
    d = q;
    base = bus.start ? '0 : q.sum;
    bidx = bus.start ? 2'h0 : q.idx;
    d.sum = base;
    d.idx = bidx;
    if (bus.valid) begin
      d.sum = bus.subtract ? AW'(base - ext) : AW'(base + ext);
      d.idx = 2'(bidx + 2'h1);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ==========================================
  // Checks
  a_sub_negates: assert property (@(posedge clk_i) disable iff (!nrst_i)
    bus.valid && !bus.start && bus.subtract |=> q.sum == AW'($past(q.sum) - $past(ext)))
    else $error("subtracted sample not negated");
  a_add_plain: assert property (@(posedge clk_i) disable iff (!nrst_i)
    bus.valid && !bus.start && !bus.subtract |=> q.sum == AW'($past(q.sum) + $past(ext)))
    else $error("added sample altered");
  a_idx_wraps: assert property (@(posedge clk_i) disable iff (!nrst_i)
    bus.valid && !bus.start && q.idx == 2'h3 |=> q.idx == 2'h0)
    else $error("pulse position did not wrap after four");

endmodule

// ### ssm_top.sv
// Slot sample math, filter bypass decode and bypass-mode channel sequencer
module ssm_top #(
  parameter int DW = 14,
  parameter int AW = 27
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic NRST_I,
  // Register port
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  output logic [15:0] REG_RDATA_O,
  // Pulse samples
  input wire logic [1:0] SLOT_START_I,
  input wire logic SAMPLE_VALID_I,
  input wire logic SAMPLE_SLOT_I,
  input wire logic [DW-1:0] SAMPLE_DATA_I,
  // Slot totals and integration polarity
  output logic [AW-1:0] SLOT_SUM_A_O,
  output logic [AW-1:0] SLOT_SUM_B_O,
  output logic [1:0] PULSE_REVERSE_O,
  // Signal path controls, bit 0 slot A, bit 1 slot B
  output logic [1:0] BAND_PASS_BYPASS_O,
  output logic [1:0] INTEG_BYPASS_O,
  output logic [1:0] INTEG_BUFFER_O,
  output logic [1:0] BUF_GAIN_LOW_O,
  // Bypass-mode converter sequencing
  input wire logic CONV_TRIG_I,
  input wire logic CONV_SLOT_I,
  output logic ADC_SAMPLE_O,
  output logic [1:0] ADC_CHAN_O,
  output logic ADC_SLOT_O
);

  localparam int SP = ssm_pkg::CHAN_SPACING_CYC;
  localparam logic [7:0] SP_LAST = 8'(ssm_pkg::CHAN_SPACING_CYC - 1);

  typedef struct packed {
    logic [3:0] order_a;
    logic [3:0] order_b;
    logic [15:0] integ_a;
    logic [15:0] integ_b;
    logic [15:0] filt_a;
    logic [15:0] filt_b;
    logic [15:0] math;
    logic [15:0] rdata;
    logic [1:0] band_pass_byp;
    logic [1:0] int_byp;
    logic [1:0] buf_en;
    logic [1:0] gain_low;
    logic [1:0] rev;
    ssm_pkg::ssm_seq_t seq;
    logic [7:0] cnt;
    logic [1:0] chan;
    logic seq_slot;
    logic adc_sample;
  } ssm_state_t;

  ssm_state_t q;
  ssm_state_t d;

  ssm_acc_if #(.DW(DW), .AW(AW)) acc_bus [2] ();

  // ==========================================
  // Per-slot accumulators
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_slot
      assign acc_bus[g].start = SLOT_START_I[g];
      assign acc_bus[g].valid = SAMPLE_VALID_I && (SAMPLE_SLOT_I == 1'(g));
      assign acc_bus[g].data = SAMPLE_DATA_I;
      ssm_sign_acc #(.DW(DW), .AW(AW)) u_acc (
        .clk_i(CLK_I),
        .nrst_i(NRST_I),
        .bus(acc_bus[g])
      );
    end
  endgenerate

  // slot B sign codes per position
  // A start sample is always the first pulse, whatever the old position
  assign acc_bus[1].subtract = ssm_pkg::ssm_sub_sel(q.math[ssm_pkg::MATH12_B_LSB +: 2],
    q.math[ssm_pkg::MATH34_B_LSB +: 2], SLOT_START_I[1] ? 2'h0 : acc_bus[1].pulse_idx);
  // slot A sign codes, pulses three and four included
  assign acc_bus[0].subtract = ssm_pkg::ssm_sub_sel(q.math[ssm_pkg::MATH12_A_LSB +: 2],
    q.math[ssm_pkg::MATH34_A_LSB +: 2], SLOT_START_I[0] ? 2'h0 : acc_bus[0].pulse_idx);

  assign SLOT_SUM_A_O = acc_bus[0].sum;
  assign SLOT_SUM_B_O = acc_bus[1].sum;
  assign REG_RDATA_O = q.rdata;
  assign PULSE_REVERSE_O = q.rev;
  assign BAND_PASS_BYPASS_O = q.band_pass_byp;
  assign INTEG_BYPASS_O = q.int_byp;
  assign INTEG_BUFFER_O = q.buf_en;
  assign BUF_GAIN_LOW_O = q.gain_low;
  assign ADC_SAMPLE_O = q.adc_sample;
  assign ADC_CHAN_O = q.chan;
  assign ADC_SLOT_O = q.seq_slot;

  // ==========================================
  // Next state
  always_comb begin
    d = q;
    d.adc_sample = 1'b0;
    // each slot has its own order, integrator and filter registers; the math register is shared
    if (REG_WR_I) begin
      case (REG_ADDR_I)
        ssm_pkg::ADDR_ORDER_A: d.order_a = REG_WDATA_I[3:0];
        ssm_pkg::ADDR_ORDER_B: d.order_b = REG_WDATA_I[3:0];
        ssm_pkg::ADDR_INTEG_A: d.integ_a = REG_WDATA_I;
        ssm_pkg::ADDR_FILT_A: d.filt_a = REG_WDATA_I;
        ssm_pkg::ADDR_INTEG_B: d.integ_b = REG_WDATA_I;
        ssm_pkg::ADDR_FILT_B: d.filt_b = REG_WDATA_I;
        ssm_pkg::ADDR_MATH: d.math = REG_WDATA_I;
        default: ;
      endcase
    end
    case (REG_ADDR_I)
      ssm_pkg::ADDR_ORDER_A: d.rdata = {12'h000, q.order_a};
      ssm_pkg::ADDR_ORDER_B: d.rdata = {12'h000, q.order_b};
      ssm_pkg::ADDR_INTEG_A: d.rdata = q.integ_a;
      ssm_pkg::ADDR_FILT_A: d.rdata = q.filt_a;
      ssm_pkg::ADDR_INTEG_B: d.rdata = q.integ_b;
      ssm_pkg::ADDR_FILT_B: d.rdata = q.filt_b;
      ssm_pkg::ADDR_MATH: d.rdata = q.math;
      default: d.rdata = 16'h0000;
    endcase
    // direct code skips filter and integrator
    // buffered code skips the filter only
    d.band_pass_byp = {ssm_pkg::ssm_band_pass_bypass(d.filt_b), ssm_pkg::ssm_band_pass_bypass(d.filt_a)};
    d.int_byp = {ssm_pkg::ssm_int_bypass(d.filt_b), ssm_pkg::ssm_int_bypass(d.filt_a)};
    d.buf_en = {d.integ_b[ssm_pkg::BUF_EN_BIT], d.integ_a[ssm_pkg::BUF_EN_BIT]} &
               {2{d.math[ssm_pkg::BUF_EN_BIT]}};
    d.gain_low = {d.integ_b[ssm_pkg::BUF_GAIN_BIT], d.integ_a[ssm_pkg::BUF_GAIN_BIT]};
    // polarity of the slot's next pulse
    d.rev = {d.order_b[acc_bus[1].pulse_idx], d.order_a[acc_bus[0].pulse_idx]};
    unique case (q.seq)
      ssm_pkg::SEQ_IDLE: begin
        if (CONV_TRIG_I && q.band_pass_byp[CONV_SLOT_I]) begin
          d.seq = ssm_pkg::SEQ_RUN;
          d.seq_slot = CONV_SLOT_I;
          d.chan = 2'h0;
          d.cnt = 8'h00;
          d.adc_sample = 1'b1;
        end
      end
      ssm_pkg::SEQ_RUN: begin
        d.cnt = 8'(q.cnt + 8'h01);
        if (q.cnt == SP_LAST) begin
          d.cnt = 8'h00;
          if (q.chan == ssm_pkg::LAST_CHAN) begin
            d.seq = ssm_pkg::SEQ_IDLE;
          end else begin
            d.chan = 2'(q.chan + 2'h1);
            d.adc_sample = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ==========================================
  // Checks
  a_slot_b_first: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    SAMPLE_VALID_I && SAMPLE_SLOT_I && !SLOT_START_I[1] && acc_bus[1].pulse_idx == 2'h0 && q.math[6]
    |=> SLOT_SUM_B_O == AW'($past(SLOT_SUM_B_O) - AW'($past(SAMPLE_DATA_I))))
    else $error("slot B first pulse not subtracted");
  a_slot_a_second: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    SAMPLE_VALID_I && !SAMPLE_SLOT_I && !SLOT_START_I[0] && acc_bus[0].pulse_idx == 2'h1 && !q.math[1]
    |=> SLOT_SUM_A_O == AW'($past(SLOT_SUM_A_O) + AW'($past(SAMPLE_DATA_I))))
    else $error("slot A second pulse not added");
  a_start_first_sign: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    SAMPLE_VALID_I && !SAMPLE_SLOT_I && SLOT_START_I[0] && q.math[2]
    |=> SLOT_SUM_A_O == AW'(AW'(0) - AW'($past(SAMPLE_DATA_I))))
    else $error("slot A first pulse after start not subtracted");
  a_slot_a_fourth: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    SAMPLE_VALID_I && !SAMPLE_SLOT_I && !SLOT_START_I[0] && acc_bus[0].pulse_idx == 2'h3 && q.math[8]
    |=> SLOT_SUM_A_O == AW'($past(SLOT_SUM_A_O) - AW'($past(SAMPLE_DATA_I))))
    else $error("slot A fourth pulse not subtracted");
  a_polarity_pick: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    acc_bus[0].pulse_idx == 2'h2 && !REG_WR_I |=> PULSE_REVERSE_O[0] == q.order_a[2])
    else $error("slot A polarity not from third bit");
  a_chan_sequence: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    ADC_SAMPLE_O && ADC_CHAN_O == 2'h0 |-> ##SP (ADC_SAMPLE_O && ADC_CHAN_O == 2'h1)
    ##SP (ADC_SAMPLE_O && ADC_CHAN_O == 2'h2) ##SP (ADC_SAMPLE_O && ADC_CHAN_O == 2'h3))
    else $error("channel samples out of order or spacing");
  a_chan_gap: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    ADC_SAMPLE_O |=> !ADC_SAMPLE_O [*8])
    else $error("channel samples too close");
  a_direct_code: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    REG_WR_I && REG_ADDR_I == ssm_pkg::ADDR_FILT_A && REG_WDATA_I == ssm_pkg::FILT_DIRECT
    |=> BAND_PASS_BYPASS_O[0] && INTEG_BYPASS_O[0])
    else $error("direct code did not bypass both stages");
  a_buffered_code: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    REG_WR_I && REG_ADDR_I == ssm_pkg::ADDR_FILT_B && REG_WDATA_I == ssm_pkg::FILT_BUFFERED
    |=> BAND_PASS_BYPASS_O[1] && !INTEG_BYPASS_O[1])
    else $error("buffered code wrong");
  a_buffer_gate: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    REG_WR_I && REG_ADDR_I == ssm_pkg::ADDR_MATH && !REG_WDATA_I[7] |=> INTEG_BUFFER_O == 2'b00)
    else $error("buffer active without math enable");
  a_gain_select: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    REG_WR_I && REG_ADDR_I == ssm_pkg::ADDR_INTEG_B |=> BUF_GAIN_LOW_O[1] == $past(REG_WDATA_I[9]))
    else $error("slot B gain select not taken");
  a_slot_independent: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    REG_WR_I && REG_ADDR_I == ssm_pkg::ADDR_FILT_A |=> BAND_PASS_BYPASS_O[1] == $past(BAND_PASS_BYPASS_O[1]))
    else $error("slot A write disturbed slot B");

endmodule

// ### tb_top.sv
// Self-checking testbench for the slot sample math block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DW = 14;
  localparam int AW = 27;
  localparam int SPACE = 1000 / 8;
  `define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
    $display("mismatch at %0t: got %0h expected %0h", $time, (a), (b)); end end
  logic clk, nrst, wr, valid, sslot, trig, cslot, asmp, aslot;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, m;
  logic [1:0] start, rev, bpass, ibyp, ibuf, glow, achan;
  logic [DW-1:0] sdata;
  logic [AW-1:0] sum_a, sum_b;
  logic signed [AW-1:0] esum [2];
  logic [3:0] ord [2];
  logic [15:0] fc [3] = '{16'hB065, 16'hAE65, 16'h1234};
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int pos [2];

  ssm_top #(.DW(DW), .AW(AW)) dut (.CLK_I(clk), .NRST_I(nrst), .REG_WR_I(wr), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .SLOT_START_I(start), .SAMPLE_VALID_I(valid),
    .SAMPLE_SLOT_I(sslot), .SAMPLE_DATA_I(sdata), .SLOT_SUM_A_O(sum_a), .SLOT_SUM_B_O(sum_b),
    .PULSE_REVERSE_O(rev), .BAND_PASS_BYPASS_O(bpass), .INTEG_BYPASS_O(ibyp), .INTEG_BUFFER_O(ibuf),
    .BUF_GAIN_LOW_O(glow), .CONV_TRIG_I(trig), .CONV_SLOT_I(cslot), .ADC_SAMPLE_O(asmp),
    .ADC_CHAN_O(achan), .ADC_SLOT_O(aslot));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  // ==========================================
  // Helpers
  function automatic logic sub_flag(input logic [15:0] mm, input logic s, input int p);
    logic [1:0] f12, f34;
    f12 = s ? mm[6:5] : mm[2:1];
    f34 = s ? mm[11:10] : mm[9:8];
    case (p)
      0: return f12[1];
      1: return f12[0];
      2: return f34[1];
      default: return f34[0];
    endcase
  endfunction

  function automatic logic is_byp(input logic [15:0] f);
    return (f == 16'hB065) || (f == 16'hAE65);
  endfunction

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    `CHK(rdata, e)
  endtask

  task automatic smp(input logic s, input logic [DW-1:0] d, input logic st);
    @(negedge clk);
    valid = 1'b1;
    sslot = s;
    sdata = d;
    start = st ? (2'b01 << s) : 2'b00;
    if (st) begin
      esum[s] = '0;
      pos[s] = 0;
    end
    if (sub_flag(m, s, pos[s])) esum[s] = esum[s] - {{(AW-DW){1'b0}}, d};
    else esum[s] = esum[s] + {{(AW-DW){1'b0}}, d};
    pos[s] = (pos[s] + 1) % 4;
  endtask

  task automatic seq(input logic s, input logic [15:0] f, input int n_exp);
    int t0, k;
    k = 0;
    wr_reg(s ? 8'h45 : 8'h43, f);
    @(negedge clk);
    trig = 1'b1;
    cslot = s;
    t0 = cyc;
    for (int i = 1; i <= 520; i++) begin
      @(negedge clk);
      trig = (i == 200);
      if (asmp === 1'b1) begin
        `CHK(cyc - t0, 1 + SPACE * k)
        `CHK(achan, k[1:0])
        `CHK(aslot, s)
        k++;
      end
    end
    `CHK(k, n_exp)
  endtask

  task automatic tally_and_finish;
    $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #200000;
    fail_count++;
    tally_and_finish;
  end

  // ==========================================
  // Main sequence
  initial begin
    logic [15:0] ia, ib;
    logic [1:0] c;
    logic sp;
    nrst = 1'b0;
    {wr, valid, sslot, trig, cslot, start, addr, wdata, sdata} = '0;
    m = '0;
    void'($urandom(85));
    repeat (8) @(posedge clk);
    `CHK({bpass, ibyp, ibuf, glow, asmp}, 9'h000)
    @(negedge clk);
    nrst = 1'b1;
    foreach (fc[i]) rd_chk(8'h42 + i[7:0], 16'h0000);
    rd_chk(8'h58, 16'h0000);
    wr_reg(8'h99, 16'hFFFF);
    rd_chk(8'h99, 16'h0000);
    for (int i = 0; i < 9; i++) begin
      wr_reg(8'h43, fc[i % 3]);
      wr_reg(8'h45, fc[i / 3]);
      @(negedge clk);
      `CHK(bpass, {is_byp(fc[i / 3]), is_byp(fc[i % 3])})
      `CHK(ibyp, {fc[i / 3] == 16'hB065, fc[i % 3] == 16'hB065})
    end
    for (int i = 0; i < 8; i++) begin
      ia = 16'($urandom);
      ib = 16'($urandom);
      ia[7] = i[0];
      ib[7] = i[1];
      m = 16'($urandom);
      m[7] = i[2];
      wr_reg(8'h42, ia);
      wr_reg(8'h44, ib);
      wr_reg(8'h58, m);
      @(negedge clk);
      `CHK(ibuf, {ib[7] & m[7], ia[7] & m[7]})
      `CHK(glow, {ib[9], ia[9]})
      rd_chk(8'h44, ib);
      rd_chk(8'h58, m);
    end
    for (int r = 0; r < 8; r++) begin
      c = r[1:0];
      m = 16'($urandom);
      if (r < 4) begin
        m[2:1] = c;
        m[9:8] = ~c;
        m[6:5] = ~c;
        m[11:10] = c;
      end
      ord[0] = 4'($urandom);
      ord[1] = 4'($urandom);
      wr_reg(8'h58, m);
      wr_reg(8'h17, {12'h000, ord[0]});
      wr_reg(8'h1D, {12'h000, ord[1]});
      smp(1'b0, (r == 0) ? 14'h3FFF : 14'($urandom), 1'b1);
      smp(1'b1, 14'($urandom), 1'b1);
      smp(1'b0, 14'($urandom), 1'b0);
      smp(1'b1, 14'($urandom), 1'b0);
      for (int j = 0; j < 2 * r; j++) begin
        if (!j[0]) sp = 1'($urandom);
        smp(sp, 14'($urandom), 1'b0);
      end
      @(negedge clk);
      valid = 1'b0;
      start = 2'b00;
      repeat (2) @(negedge clk);
      `CHK(sum_a, esum[0])
      `CHK(sum_b, esum[1])
      `CHK(rev, {ord[1][pos[1]], ord[0][pos[0]]})
    end
    seq(1'b0, 16'hB065, 4);
    seq(1'b1, 16'hAE65, 4);
    seq(1'b0, 16'h1234, 0);
    tally_and_finish;
  end
endmodule
